/* rtl/capcmp_pkg.sv */
// Constants shared by the capture/compare pair and its helpers.
// Assumes a 16-bit count and a 16-bit register port.
package capcmp_pkg;

	// ********************************************************
	// Register addresses
	// ********************************************************
	localparam logic [15:0] ADDR_CC_A  = 16'hff14;
	localparam logic [15:0] ADDR_CC_B  = 16'hff16;
	localparam logic [15:0] ADDR_CTRL  = 16'hff62;
	localparam logic [15:0] ADDR_PRM   = 16'hff66;
	localparam logic [15:0] ADDR_STAT  = 16'hff68;

	// ********************************************************
	// Reset values and write masks
	// ********************************************************
	localparam logic [15:0] CC_RESET   = 16'h0000;
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [7:0]  PRM_RESET  = 8'h00;
	localparam logic [7:0]  CTRL_WMASK = 8'h07;
	localparam logic [7:0]  PRM_WMASK  = 8'hf3;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int CTRL_A_MODE   = 0;
	localparam int CTRL_A_TRIG   = 1;
	localparam int CTRL_B_MODE   = 2;
	localparam int PRM_EDGE_A_LO = 4;
	localparam int PRM_EDGE_B_LO = 6;
	localparam int STAT_CAP_A    = 0;
	localparam int STAT_CAP_B    = 1;
	localparam int STAT_PIN_A    = 2;
	localparam int STAT_PIN_B    = 3;

	// ********************************************************
	// Edge codes, timer modes, count marks
	// ********************************************************
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] MODE_STOP      = 2'h0;
	localparam logic [1:0] MODE_FREE      = 2'h1;
	localparam logic [1:0] MODE_CLR_EDGE  = 2'h2;
	localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE  = 16'h0001;
	localparam logic [15:0] COUNT_MAX  = 16'hffff;

	// Selected edge seen; the forbidden code matches nothing
	function automatic logic edge_hit(input logic [1:0] code,
		input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		case (code)
			EDGE_FALL: hit = fall;
			EDGE_RISE: hit = rise;
			EDGE_BOTH: hit = rise | fall;
			default:   hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Opposite edge to the selected one; both-edges never hits
	function automatic logic edge_hit_inv(input logic [1:0] code,
		input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		case (code)
			EDGE_FALL: hit = rise;
			EDGE_RISE: hit = fall;
			default:   hit = 1'b0;
		endcase
		return hit;
	endfunction

endpackage

/* rtl/edge_sync.sv */
// Two-flop synchroniser and edge detector for one trigger pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// Shift the pin through two stages, then keep one old sample
	always_comb begin
		st_nxt       = st_r;
		st_nxt.sync1 = pin;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev  = st_r.sync2;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// One pulse per edge, from synchronised samples only
	assign level = st_r.sync2;
	assign rise  = st_r.sync2 & ~st_r.prev;
	assign fall  = ~st_r.sync2 & st_r.prev;

endmodule
`default_nettype wire

/* rtl/capcmp_reg.sv */
// One 16-bit capture/compare holding register.
// Assumes write and capture strobes are on the clk domain.
`timescale 1ns/100ps
`default_nettype none
module capcmp_reg (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic        cap_en,
	input  wire logic [15:0] cap_data,
	output logic      [15:0] value
);

	typedef struct packed {
		logic [15:0] value;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// Capture takes precedence over a software write
	always_comb begin
		st_nxt = st_r;
		if (cap_en) begin
			st_nxt.value = cap_data;
		end else if (wr_en) begin
			st_nxt.value = wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r.value <= capcmp_pkg::CC_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign value = st_r.value;

endmodule
`default_nettype wire

/* rtl/timer_capture_compare_pair.sv */
// Two capture/compare registers beside a 16-bit up-counter.
// Assumes the counter lives outside, on clk, and pulses count_step
// in the cycle its new value appears on timer_count.
// Pins arrive raw and are synchronised here; the register port is
// a plain strobe bus whose read data stand one cycle after rd_en.
// No interrupt logic of its own: match pulses go to the core.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module timer_capture_compare_pair (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [15:0] rd_data_r,
	input  wire logic        trigger_in_a,
	input  wire logic        trigger_in_b,
	input  wire logic [2:0]  timer_mode,
	input  wire logic        count_step,
	input  wire logic [15:0] timer_count,
	output logic      [15:0] interval_len,
	output logic             match_irq_a_r,
	output logic             match_irq_b_r,
	output logic             match_clear_r,
	output logic             trig_edge_a_r
);

	// ********************************************************
	// State
	// ********************************************************
	// All state but the synchronisers and holding registers lives in one struct, registered in one place
	typedef struct packed {
		logic [7:0]  capcmp_ctrl_reg;
		logic [7:0]  prescaler_mode_reg;
		logic [1:0]  cap_flag;
		logic [15:0] prev_count;
		logic        wrapped;
		logic [15:0] rd_data;
		logic        irq_a;
		logic        irq_b;
		logic        clear;
		logic        edge_a;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// ********************************************************
	// Trigger pin synchronisers
	// ********************************************************
	logic lvl_a;
	logic rise_a;
	logic fall_a;
	logic lvl_b;
	logic rise_b;
	logic fall_b;

	// Both pins are asynchronous to clk; nothing reads them raw
	// Pin A synchronised before any edge logic sees it
	edge_sync u_sync_a (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (trigger_in_a),
		.level (lvl_a),
		.rise  (rise_a),
		.fall  (fall_a)
	);

	// Pin B shares its pad with the timer output elsewhere
	edge_sync u_sync_b (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (trigger_in_b),
		.level (lvl_b),
		.rise  (rise_b),
		.fall  (fall_b)
	);

	// ********************************************************
	// Control field decode
	// ********************************************************
	logic       run;
	logic       zero_ok;
	logic       reg_a_mode_sel;
	logic       reg_a_trigger_sel;
	logic       reg_b_mode_sel;
	logic [1:0] edge_a_sel;
	logic [1:0] edge_b_sel;

	// Control writes are expected only while the timer is stopped
	// Mode bits of the control register
	assign reg_a_mode_sel    =
		st_r.capcmp_ctrl_reg[capcmp_pkg::CTRL_A_MODE];
	assign reg_a_trigger_sel =
		st_r.capcmp_ctrl_reg[capcmp_pkg::CTRL_A_TRIG];
	assign reg_b_mode_sel    =
		st_r.capcmp_ctrl_reg[capcmp_pkg::CTRL_B_MODE];

	// Code 10 is forbidden; the edge decoders treat it as no edge
	// Edge fields of the prescaler mode register
	assign edge_a_sel = st_r.prescaler_mode_reg[
		capcmp_pkg::PRM_EDGE_A_LO +: 2];
	assign edge_b_sel = st_r.prescaler_mode_reg[
		capcmp_pkg::PRM_EDGE_B_LO +: 2];

	// Timer running, and modes where a zero compare may fire
	// Registers simply hold while stopped; their contents then carry
	// no promise, so software reloads them before a restart
	assign run     =
		timer_mode[2:1] != capcmp_pkg::MODE_STOP;
	assign zero_ok = (timer_mode[2:1] == capcmp_pkg::MODE_FREE) ||
		(timer_mode[2:1] == capcmp_pkg::MODE_CLR_EDGE);

	// ********************************************************
	// Capture triggers
	// ********************************************************
	logic hit_a_norm;
	logic hit_a_inv;
	logic hit_b_norm;
	logic cap_a;
	logic cap_b;

	// Edge pulses come two flops after the pin, so a capture lands
	// three edges after the pin change; narrow pulses may be lost
	// A mode bit of zero blocks every edge for that register
	// Valid edges per pin; code 10 never hits
	assign hit_a_norm = capcmp_pkg::edge_hit(edge_a_sel, rise_a,
		fall_a);
	assign hit_a_inv  = capcmp_pkg::edge_hit_inv(edge_a_sel, rise_a,
		fall_a);
	assign hit_b_norm = capcmp_pkg::edge_hit(edge_b_sel, rise_b,
		fall_b);

	// Register A sees pin A in reverse phase, pin B in phase
	// Register A picks pin A reversed or pin B straight
	assign cap_a = run & reg_a_mode_sel &
		(reg_a_trigger_sel ? hit_a_inv : hit_b_norm);

	// Register B sees pin A in phase; pin B serves register A only
	// Register B captures from pin A only
	assign cap_b = run & reg_b_mode_sel & hit_a_norm;

	// ********************************************************
	// Holding registers
	// ********************************************************
	logic [15:0] cc_val [2];
	logic [1:0]  cc_wr;
	logic [1:0]  cc_cap;
	logic [1:0]  cc_cmp;
	logic [1:0]  match;

	// A capture into a register beats a write in the same cycle;
	// the write is dropped and software must retry it
	// Word writes only; no byte lanes exist on this port
	assign cc_wr[0] = wr_en && (addr == capcmp_pkg::ADDR_CC_A);
	assign cc_wr[1] = wr_en && (addr == capcmp_pkg::ADDR_CC_B);
	assign cc_cap   = {cap_b, cap_a};
	assign cc_cmp   = {~reg_b_mode_sel, ~reg_a_mode_sel};

	// Register A, cleared to zero at reset
	capcmp_reg u_cc_a (
		.clk      (clk),
		.rst_b    (rst_b),
		.wr_en    (cc_wr[0]),
		.wr_data  (wr_data),
		.cap_en   (cc_cap[0]),
		.cap_data (timer_count),
		.value    (cc_val[0])
	);

	// Register B, cleared to zero at reset
	capcmp_reg u_cc_b (
		.clk      (clk),
		.rst_b    (rst_b),
		.wr_en    (cc_wr[1]),
		.wr_data  (wr_data),
		.cap_en   (cc_cap[1]),
		.cap_data (timer_count),
		.value    (cc_val[1])
	);

	// In clear-on-match mode the counter restarts from zero on reaching this value
	// Counter reads its interval length straight from register A
	assign interval_len = cc_val[0];

	// ********************************************************
	// Compare logic, one copy per register
	// ********************************************************
	// A zero value never matches on plain equality: the step from
	// zero after reset or a clear would fire falsely. It fires only
	// on the step to one that follows a wrap, in modes 01 and 10.
	// A value below the present count is reached after overflow.
	// One generate copy per register keeps the two paths identical.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
			logic eq_hit;
			logic zero_hit;
			// Only steps count; a stalled counter cannot match twice
			// Plain equality on each new count value
			assign eq_hit = (cc_val[gi] != capcmp_pkg::COUNT_ZERO) &&
				(timer_count == cc_val[gi]);
			// Zero compare fires on the step to one after a wrap
			assign zero_hit = zero_ok && st_r.wrapped &&
				(cc_val[gi] == capcmp_pkg::COUNT_ZERO) &&
				(timer_count == capcmp_pkg::COUNT_ONE);
			assign match[gi] = run & cc_cmp[gi] & count_step &
				(eq_hit | zero_hit);
		end
	endgenerate

	// ********************************************************
	// Status word and read mux
	// ********************************************************
	logic [15:0] stat_word;
	logic [15:0] rd_mux;

	// Status layout: capture flags in bits 1:0, pin levels in 3:2
	// Levels come from the second synchroniser stage only
	// Sticky capture flags and synchronised pin levels
	always_comb begin
		stat_word = 16'h0000;
		stat_word[capcmp_pkg::STAT_CAP_A] = st_r.cap_flag[0];
		stat_word[capcmp_pkg::STAT_CAP_B] = st_r.cap_flag[1];
		stat_word[capcmp_pkg::STAT_PIN_A] = lvl_a;
		stat_word[capcmp_pkg::STAT_PIN_B] = lvl_b;
	end

	// Unmapped addresses read as zero
	// Read data; a coinciding capture shows the old value
	always_comb begin
		rd_mux = 16'h0000;
		case (addr)
			capcmp_pkg::ADDR_CC_A: rd_mux = cc_val[0];
			capcmp_pkg::ADDR_CC_B: rd_mux = cc_val[1];
			capcmp_pkg::ADDR_CTRL: rd_mux = {8'h00, st_r.capcmp_ctrl_reg};
			capcmp_pkg::ADDR_PRM:  rd_mux = {8'h00, st_r.prescaler_mode_reg};
			capcmp_pkg::ADDR_STAT: rd_mux = stat_word;
			default:               rd_mux = 16'h0000;
		endcase
	end

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb begin
		st_nxt = st_r;

		// Control and edge registers; reserved bits stay zero
		// Bits 1:0 of the prescaler word are stored but unused here
		if (wr_en && (addr == capcmp_pkg::ADDR_CTRL)) begin
			st_nxt.capcmp_ctrl_reg = wr_data[7:0] & capcmp_pkg::CTRL_WMASK;
		end
		if (wr_en && (addr == capcmp_pkg::ADDR_PRM)) begin
			st_nxt.prescaler_mode_reg =
				wr_data[7:0] & capcmp_pkg::PRM_WMASK;
		end

		// Capture flags: write one clears, a new capture wins
		if (wr_en && (addr == capcmp_pkg::ADDR_STAT)) begin
			st_nxt.cap_flag = st_r.cap_flag & ~wr_data[1:0];
		end
		st_nxt.cap_flag = st_nxt.cap_flag | {cap_b, cap_a};
		// A clear and a new capture in one cycle leave the flag set,
		// so no capture is ever lost to software

		// Track the step from the top count back to zero
		if (count_step) begin
			st_nxt.prev_count = timer_count;
			st_nxt.wrapped = (st_r.prev_count == capcmp_pkg::COUNT_MAX) &&
				(timer_count == capcmp_pkg::COUNT_ZERO);
		end
		if (!run) begin
			st_nxt.wrapped = 1'b0;
		end

		// Idle cycles drive zero so a late sample cannot pass by luck
		// Read answer stands only in the cycle after the strobe
		st_nxt.rd_data = rd_en ? rd_mux : 16'h0000;

		// Capture data and its interrupt show on the same edge, one
		// edge after the synchronised pin edge is seen
		// Interrupts load on the same edge as the capture
		st_nxt.irq_a = match[0] | cap_a;
		st_nxt.irq_b = match[1] | cap_b;

		// The counter outside clears itself when this pulse is seen
		// Restart request for clear-on-match mode
		st_nxt.clear = match[0] &&
			(timer_mode[2:1] == capcmp_pkg::MODE_CLR_MATCH);

		// Valid pin A edge for clear-on-edge counting
		st_nxt.edge_a = run & hit_a_norm;
	end

	// ********************************************************
	// State register
	// ********************************************************
	// Asynchronous reset loads constants only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
			st_r.capcmp_ctrl_reg <= capcmp_pkg::CTRL_RESET;
			st_r.prescaler_mode_reg <= capcmp_pkg::PRM_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Every output is a flop; interval_len is register A's flop
	// Registered outputs
	assign rd_data_r     = st_r.rd_data;
	assign match_irq_a_r = st_r.irq_a;
	assign match_irq_b_r = st_r.irq_b;
	assign match_clear_r = st_r.clear;
	assign trig_edge_a_r = st_r.edge_a;

endmodule
`default_nettype wire

/* dv/capcmp_checker.sv */
// Port assertions for timer_capture_compare_pair.
// Assumes control writes happen while the timer is stopped.
`timescale 1ns/100ps
`default_nettype none
module capcmp_checker (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [15:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic        wr_en,
	input wire logic        trigger_in_a,
	input wire logic [2:0]  timer_mode,
	input wire logic        count_step,
	input wire logic [15:0] timer_count,
	input wire logic [15:0] interval_len,
	input wire logic        match_irq_a_r,
	input wire logic        match_irq_b_r,
	input wire logic        match_clear_r,
	input wire logic        trig_edge_a_r
);
	logic [2:0] ctrl_r;
	logic [1:0] edge_a_r;
	logic       run;
	logic       wr_a;

	// Shadow of mode bits and pin A edge code
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r   <= 3'h0;
			edge_a_r <= 2'h0;
		end else if (wr_en && addr == capcmp_pkg::ADDR_CTRL) begin
			ctrl_r <= wr_data[2:0];
		end else if (wr_en && addr == capcmp_pkg::ADDR_PRM) begin
			edge_a_r <= wr_data[5:4];
		end
	end
	// Decodes
	assign run  = timer_mode[2:1] != capcmp_pkg::MODE_STOP;
	assign wr_a = wr_en && addr == capcmp_pkg::ADDR_CC_A;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Capture steps: pin edge, then interrupt
	sequence pin_a_rise;
		$rose(trigger_in_a) ##0 run;
	endsequence
	sequence irq_b_soon;
		##[3:5] match_irq_b_r;
	endsequence

	rst_clear_a: assert property (
		$rose(rst_b) |-> interval_len == 16'h0000 && !match_irq_a_r)
		else $error("A not clear after reset");
	write_a_a: assert property (
		wr_a |=> interval_len == $past(wr_data) || match_irq_a_r)
		else $error("A write lost");
	hold_a_a: assert property (
		!$past(wr_a) && !match_irq_a_r |-> $stable(interval_len))
		else $error("A changed without cause");
	cmp_a_a: assert property (
		count_step && run && !ctrl_r[0] && interval_len != 16'h0000
		&& timer_count == interval_len |=> match_irq_a_r)
		else $error("A match missed");
	cause_a_a: assert property (
		match_irq_a_r && !ctrl_r[0] |-> $past(count_step))
		else $error("A irq without count step");
	clear_a_a: assert property (
		match_clear_r |-> match_irq_a_r
		&& timer_mode[2:1] == capcmp_pkg::MODE_CLR_MATCH)
		else $error("clear without A match");
	cap_b_a: assert property (
		pin_a_rise ##0 (ctrl_r[2] && edge_a_r == capcmp_pkg::EDGE_RISE)
		|-> irq_b_soon)
		else $error("B capture irq missing");
	edge_a_a: assert property (
		pin_a_rise ##0 edge_a_r == capcmp_pkg::EDGE_RISE
		|-> ##3 trig_edge_a_r)
		else $error("pin A edge pulse missing");
	pulse_b_a: assert property (
		match_irq_b_r |=> !match_irq_b_r)
		else $error("B irq too long");
endmodule

bind timer_capture_compare_pair capcmp_checker chk (
	.clk, .rst_b, .addr, .wr_data, .wr_en, .trigger_in_a, .timer_mode,
	.count_step, .timer_count, .interval_len, .match_irq_a_r,
	.match_irq_b_r, .match_clear_r, .trig_edge_a_r
);
`default_nettype wire

/* dv/trig_src.sv */
// Outside signal sources on the two trigger pins.
// Assumes drive() is called just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module trig_src (
	input  wire logic clk,
	output var logic  trigger_in_a,
	output var logic  trigger_in_b
);
	// Pins rest low
	initial begin
		trigger_in_a = 1'b0;
		trigger_in_b = 1'b0;
	end
	// Sets a pin and holds it n clocks; pin B serves only as input
	task automatic drive(input logic sel, input logic lvl, input int n);
		if (sel)
			trigger_in_b <= lvl;
		else
			trigger_in_a <= lvl;
		repeat (n) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* dv/tb_timer_capture_compare_pair.sv */
// Self-checking bench for timer_capture_compare_pair.
// Assumes the bound checker and the trig_src pin model.
`timescale 1ns/100ps
`default_nettype none
module tb_timer_capture_compare_pair;
	logic        clk, rst_b, wr_en, rd_en, count_step, sel_b;
	logic        trigger_in_a, trigger_in_b, match_clear_r;
	logic        match_irq_a_r, match_irq_b_r;
	logic [2:0]  timer_mode;
	logic [15:0] addr, wr_data, rd_data_r, timer_count;
	logic [15:0] start_val, interval_len, cap_exp;
	int          n_irq, err_total, compares;

	timer_capture_compare_pair DUT (
		.clk, .rst_b, .addr, .wr_data, .wr_en, .rd_en, .rd_data_r,
		.trigger_in_a, .trigger_in_b, .timer_mode, .count_step,
		.timer_count, .interval_len, .match_irq_a_r, .match_irq_b_r,
		.match_clear_r, .trig_edge_a_r()
	);
	trig_src pins (.clk, .trigger_in_a, .trigger_in_b);

	// Count clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Outside counter: preset while stopped, cleared on match
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_step  <= 1'b0;
			timer_count <= 16'h0000;
		end else begin
			count_step <= timer_mode[2:1] != capcmp_pkg::MODE_STOP;
			if (timer_mode[2:1] == capcmp_pkg::MODE_STOP)
				timer_count <= start_val;
			else if (match_clear_r)
				timer_count <= 16'h0000;
			else
				timer_count <= timer_count + 16'h0001;
		end
	end
	// Counts watched interrupts; a capture holds the count before
	always @(posedge clk) begin
		if (sel_b ? match_irq_b_r : match_irq_a_r) begin
			n_irq++;
			cap_exp <= timer_count - 16'h0001;
		end
	end

	// *****
	// Access tasks
	// *****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Full 16-bit word write
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [15:0] e);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data_r, e);
		@(posedge clk);
	endtask
	task automatic run(input logic [1:0] m);
		timer_mode <= {m, 1'b0};
		@(posedge clk);
		#1;
	endtask
	// Waits for an interrupt and checks the count beside it
	task automatic wirq(input logic b, input logic [15:0] e, input int lim);
		int i;
		i = 0;
		#1;
		while ((b ? match_irq_b_r : match_irq_a_r) !== 1'b1
			&& i < lim) begin
			@(posedge clk);
			#1;
			i++;
		end
		if (i >= lim) begin
			err_total++;
			$display("MISMATCH %0t: interrupt wait ran out", $time);
		end
		chk(timer_count, e);
		@(posedge clk);
		#1;
	endtask
	// One pin pulse; irq counts in the high and low phases
	task automatic cap(input logic [7:0] c, input logic [7:0] p,
		input logic pb, input logic ib, input int er, input int ef);
		int nr;
		logic [15:0] st_exp;
		wr(capcmp_pkg::ADDR_CTRL, {8'h00, c});
		wr(capcmp_pkg::ADDR_PRM, {8'h00, p});
		wr(capcmp_pkg::ADDR_STAT, 16'h0003);
		wr(ib ? capcmp_pkg::ADDR_CC_B : capcmp_pkg::ADDR_CC_A, 16'h0f0f);
		cap_exp = 16'h0f0f;
		st_exp = 16'h0000;
		if (er + ef > 0)
			st_exp = ib ? 16'h0002 : 16'h0001;
		sel_b = ib;
		n_irq = 0;
		run(capcmp_pkg::MODE_FREE);
		pins.drive(pb, 1'b1, 8);
		#1;
		nr = n_irq;
		pins.drive(pb, 1'b0, 8);
		#1;
		chk(16'(nr), 16'(er));
		chk(16'(n_irq - nr), 16'(ef));
		if (ib)
			rdc(capcmp_pkg::ADDR_CC_B, cap_exp);
		else
			chk(interval_len, cap_exp);
		rdc(capcmp_pkg::ADDR_STAT, st_exp);
		run(capcmp_pkg::MODE_STOP);
		$display("capture test %h %h done", c, p);
	endtask
	task automatic results;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// *****
	// Tests; setup only while stopped
	// *****
	initial begin
		{rst_b, wr_en, rd_en, sel_b} = 4'h0;
		{addr, wr_data, start_val} = 48'h0;
		timer_mode = 3'h0;
		{n_irq, err_total, compares} = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk(interval_len, 16'h0000);
		rdc(capcmp_pkg::ADDR_CC_B, 16'h0000);
		wr(capcmp_pkg::ADDR_CTRL, 16'hffff);
		rdc(capcmp_pkg::ADDR_CTRL, 16'h0007);
		wr(capcmp_pkg::ADDR_PRM, 16'hffff);
		rdc(capcmp_pkg::ADDR_PRM, 16'h00f3);
		wr(16'hff00, 16'h5a5a);
		rdc(16'hff00, 16'h0000);
		$display("register test done");
		wr(capcmp_pkg::ADDR_CTRL, 16'h0000);
		wr(capcmp_pkg::ADDR_CC_A, 16'h0040);
		wr(capcmp_pkg::ADDR_CC_B, 16'h0050);
		run(capcmp_pkg::MODE_FREE);
		wirq(1'b0, 16'h0041, 100);
		wirq(1'b1, 16'h0051, 40);
		run(capcmp_pkg::MODE_STOP);
		wr(capcmp_pkg::ADDR_CC_A, 16'h0010);
		run(capcmp_pkg::MODE_CLR_MATCH);
		wirq(1'b0, 16'h0011, 40);
		wirq(1'b0, 16'h0011, 40);
		run(capcmp_pkg::MODE_STOP);
		$display("compare test done");
		start_val = 16'h0100;
		wr(capcmp_pkg::ADDR_CC_A, 16'h0080);
		wr(capcmp_pkg::ADDR_CC_B, 16'h0000);
		n_irq = 0;
		run(capcmp_pkg::MODE_FREE);
		wirq(1'b1, 16'h0002, 70000);
		wirq(1'b0, 16'h0081, 200);
		chk(16'(n_irq), 16'h0001);
		run(capcmp_pkg::MODE_STOP);
		start_val = 16'h0000;
		$display("wrap test done");
		// Every legal edge code; code 10 is never written
		cap(8'h00, 8'h30, 1'b0, 1'b1, 0, 0);
		cap(8'h04, 8'h00, 1'b0, 1'b1, 0, 1);
		cap(8'h04, 8'h10, 1'b0, 1'b1, 1, 0);
		cap(8'h04, 8'h30, 1'b0, 1'b1, 1, 1);
		cap(8'h03, 8'h00, 1'b0, 1'b0, 1, 0);
		cap(8'h03, 8'h10, 1'b0, 1'b0, 0, 1);
		cap(8'h03, 8'h30, 1'b0, 1'b0, 0, 0);
		cap(8'h01, 8'h00, 1'b1, 1'b0, 0, 1);
		cap(8'h01, 8'h40, 1'b1, 1'b0, 1, 0);
		cap(8'h01, 8'hc0, 1'b1, 1'b0, 1, 1);
		results;
	end
	// Watchdog against a hang
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		$display("MISMATCH %0t: run did not finish", $time);
		results;
	end
endmodule
`default_nettype wire
